//--- overtravel_pkg.sv
// Purpose: shared constants and types for the overtravel/direction block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes:   all offsets, field positions and reset values live here, except limit_enable, reset to 1 in the block, and the limit_sync flops, reset to all ones
`default_nettype none
package overtravel_pkg;

   // ===========================================================
   // register offsets
   localparam logic [7:0] CONFIG_OFFSET     = 8'h00;
   localparam logic [7:0] RESTART_OFFSET    = 8'h04;
   localparam logic [7:0] ALLOC_OFFSET      = 8'h08;
   localparam logic [7:0] STATUS_OFFSET     = 8'h0c;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h14;

   // ===========================================================
   // config, restart and allocation register fields
   localparam int DIR_SEL_BIT     = 0;
   localparam int FWD_DIS_BIT     = 1;
   localparam int REV_DIS_BIT     = 2;
   localparam int STOP_SEL_LSB    = 3;
   localparam int RESTART_BIT     = 0;
   localparam int ALLOC_FWD_LSB   = 0;
   localparam int ALLOC_REV_LSB   = 4;

   // ===========================================================
   // values after reset
   localparam logic       DIR_SEL_RESET  = 1'b0;
   localparam logic       FWD_DIS_RESET  = 1'b0;
   localparam logic       REV_DIS_RESET  = 1'b0;
   localparam logic [1:0] STOP_SEL_RESET = 2'h0;
   localparam logic [3:0] ALLOC_FWD_CODE = 4'h1;
   localparam logic [3:0] ALLOC_REV_CODE = 4'h2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // ===========================================================
   // status and interrupt bit positions
   localparam int ST_FWD_OT   = 0;
   localparam int ST_REV_OT   = 1;
   localparam int ST_STOPPING = 2;
   localparam int ST_CLAMP    = 3;
   localparam int ST_COAST    = 4;
   localparam int ST_DBRAKE   = 5;
   localparam int ST_LIMIT_ON = 6;
   localparam int IRQ_FWD_OT  = 0;
   localparam int IRQ_REV_OT  = 1;
   localparam int IRQ_STOPPED = 2;
   localparam int IRQ_WIDTH   = 3;

   // ===========================================================
   // overtravel stop selection
   typedef enum logic [1:0] {
      STOP_DB_COAST     = 2'b00,
      STOP_COAST        = 2'b01,
      STOP_REV_CLAMP    = 2'b10,
      STOP_REV_COAST    = 2'b11
   } stop_select_type;

   // stop sequence states
   typedef enum logic [2:0] {
      MOTION_RUN   = 3'b000,
      MOTION_DB    = 3'b001,
      MOTION_FREE  = 3'b010,
      MOTION_RBRK  = 3'b011,
      MOTION_CLAMP = 3'b100,
      MOTION_IDLE  = 3'b101
   } motion_state_type;

endpackage
`default_nettype wire

//--- limit_sync.sv
// Purpose: two-stage synchroniser for one limit switch input
// Assumes: single clock, synchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module limit_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // raw and synchronised level
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic meta;
      logic held;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   // ===========================================================
   // shift the level through two flops
   always_comb begin
      next_state.meta = async_in;
      next_state.held = state.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state <= '1;   // run-allowed level, no false overtravel edge
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.held;

endmodule
`default_nettype wire

//--- overtravel_direction_logic.sv
// Purpose: rotation sense, divided encoder phase order and overtravel stop
// Assumes: references, encoder steps and stopped flag come from the drive
// Notes:   config and allocation apply only on a restart command
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module overtravel_direction_logic (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata,
   output logic             irq,
   // limit switches, high means run allowed
   input  wire logic        forward_limit_input,
   input  wire logic        reverse_limit_input,
   // motion references and feedback
   input  wire logic        forward_ref,
   input  wire logic        reverse_ref,
   input  wire logic        motor_stopped,
   input  wire logic        encoder_step,
   input  wire logic [31:0] position_in,
   // drive outputs
   output logic             rotate_cw,
   output logic             rotate_ccw,
   output logic             dynamic_brake,
   output logic             reverse_brake,
   output logic             coasting,
   output logic             zero_clamp,
   output logic [31:0]      clamp_position,
   output logic             divided_phase_a_out,
   output logic             divided_phase_b_out
);
   import overtravel_pkg::*;

   typedef struct packed {
      // pending settings, written by software
      logic                 dir_pend;
      logic                 fwd_dis_pend;
      logic                 rev_dis_pend;
      logic [1:0]           stop_pend;
      logic [3:0]           alloc_fwd_pend;
      logic [3:0]           alloc_rev_pend;
      // active settings, loaded on restart
      logic                 direction_select;
      logic                 forward_limit_disable;
      logic                 reverse_limit_disable;
      stop_select_type      overtravel_stop_select;
      logic                 limit_enable;
      // runtime
      motion_state_type     motion;
      logic                 fwd_ot_prev;
      logic                 rev_ot_prev;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic [1:0]           quad;
      logic [31:0]          clamp_pos;
      logic [31:0]          rdata;
   } ot_state_type;

   ot_state_type state;
   ot_state_type next_state;

   logic fwd_limit_sync;
   logic rev_limit_sync;
   logic forward_ot;
   logic reverse_ot;
   logic prohibited;
   logic [IRQ_WIDTH-1:0] irq_events;
   logic [31:0] status_word;

   // ===========================================================
   // limit input synchronisers
   limit_sync fwd_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .async_in (forward_limit_input),
      .sync_out (fwd_limit_sync)
   );

   limit_sync rev_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .async_in (reverse_limit_input),
      .sync_out (rev_limit_sync)
   );

   // ===========================================================
   // overtravel decode from synchronised levels
   always_comb begin
      forward_ot = state.limit_enable && !state.forward_limit_disable
                   && !fwd_limit_sync;
      reverse_ot = state.limit_enable && !state.reverse_limit_disable
                   && !rev_limit_sync;
      prohibited = (forward_ot && forward_ref)
                   || (reverse_ot && reverse_ref);
   end

   // status word seen by software
   always_comb begin
      status_word = '0;
      status_word[ST_FWD_OT]   = forward_ot;
      status_word[ST_REV_OT]   = reverse_ot;
      status_word[ST_STOPPING] = (state.motion == MOTION_DB)
                                 || (state.motion == MOTION_FREE)
                                 || (state.motion == MOTION_RBRK);
      status_word[ST_CLAMP]    = state.motion == MOTION_CLAMP;
      status_word[ST_COAST]    = coasting;
      status_word[ST_DBRAKE]   = dynamic_brake;
      status_word[ST_LIMIT_ON] = state.limit_enable;
   end

   // ===========================================================
   // next state
   always_comb begin
      next_state = state;
      irq_events = '0;

      // register writes
      if (reg_write) begin
         unique case (reg_addr)
            CONFIG_OFFSET: begin
               next_state.dir_pend     = reg_wdata[DIR_SEL_BIT];
               next_state.fwd_dis_pend = reg_wdata[FWD_DIS_BIT];
               next_state.rev_dis_pend = reg_wdata[REV_DIS_BIT];
               next_state.stop_pend    = reg_wdata[STOP_SEL_LSB +: 2];
            end
            ALLOC_OFFSET: begin
               next_state.alloc_fwd_pend = reg_wdata[ALLOC_FWD_LSB +: 4];
               next_state.alloc_rev_pend = reg_wdata[ALLOC_REV_LSB +: 4];
            end
            IRQ_MASK_OFFSET: begin
               next_state.irq_mask = reg_wdata[IRQ_WIDTH-1:0];
            end
            default: begin
            end
         endcase
      end

      // restart applies the pending settings
      if (reg_write && reg_addr == RESTART_OFFSET
          && reg_wdata[RESTART_BIT]) begin
         next_state.direction_select       = state.dir_pend;
         next_state.forward_limit_disable  = state.fwd_dis_pend;
         next_state.reverse_limit_disable  = state.rev_dis_pend;
         next_state.overtravel_stop_select =
            stop_select_type'(state.stop_pend);
         next_state.limit_enable =
            (state.alloc_fwd_pend == ALLOC_FWD_CODE)
            && (state.alloc_rev_pend == ALLOC_REV_CODE);
      end

      // stop sequence
      unique case (state.motion)
         MOTION_RUN: begin
            if (prohibited) begin
               unique case (state.overtravel_stop_select)
                  STOP_DB_COAST:  next_state.motion = MOTION_DB;
                  STOP_COAST:     next_state.motion = MOTION_FREE;
                  STOP_REV_CLAMP: next_state.motion = MOTION_RBRK;
                  STOP_REV_COAST: next_state.motion = MOTION_RBRK;
               endcase
            end
         end
         MOTION_DB, MOTION_FREE: begin
            if (motor_stopped) begin
               next_state.motion = MOTION_IDLE;
               irq_events[IRQ_STOPPED] = 1'b1;
            end
         end
         MOTION_RBRK: begin
            if (motor_stopped) begin
               irq_events[IRQ_STOPPED] = 1'b1;
               if (state.overtravel_stop_select == STOP_REV_CLAMP) begin
                  next_state.motion    = MOTION_CLAMP;
                  next_state.clamp_pos = position_in;
               end else begin
                  next_state.motion = MOTION_IDLE;
               end
            end
         end
         MOTION_CLAMP, MOTION_IDLE: begin
            if (!prohibited) begin
               next_state.motion = MOTION_RUN;
            end
         end
         default: begin
            next_state.motion = MOTION_RUN;
         end
      endcase

      // divided encoder quadrature, gray order by reference sense
      if (encoder_step && (forward_ref != reverse_ref)) begin
         if (forward_ref) begin
            next_state.quad = {state.quad[0], ~state.quad[1]};
         end else begin
            next_state.quad = {~state.quad[0], state.quad[1]};
         end
      end

      // overtravel entry events
      irq_events[IRQ_FWD_OT] = forward_ot && !state.fwd_ot_prev;
      irq_events[IRQ_REV_OT] = reverse_ot && !state.rev_ot_prev;
      next_state.fwd_ot_prev = forward_ot;
      next_state.rev_ot_prev = reverse_ot;

      // sticky status, set wins over write-one clear
      if (reg_write && reg_addr == IRQ_STATUS_OFFSET) begin
         next_state.irq_status = state.irq_status
                                 & ~reg_wdata[IRQ_WIDTH-1:0];
      end
      next_state.irq_status = next_state.irq_status | irq_events;

      // read data, valid the cycle after the strobe
      next_state.rdata = '0;
      if (reg_read) begin
         unique case (reg_addr)
            CONFIG_OFFSET: begin
               next_state.rdata[DIR_SEL_BIT]        = state.dir_pend;
               next_state.rdata[FWD_DIS_BIT]        = state.fwd_dis_pend;
               next_state.rdata[REV_DIS_BIT]        = state.rev_dis_pend;
               next_state.rdata[STOP_SEL_LSB +: 2]  = state.stop_pend;
            end
            ALLOC_OFFSET: begin
               next_state.rdata[ALLOC_FWD_LSB +: 4] = state.alloc_fwd_pend;
               next_state.rdata[ALLOC_REV_LSB +: 4] = state.alloc_rev_pend;
            end
            STATUS_OFFSET: begin
               next_state.rdata = status_word;
            end
            IRQ_STATUS_OFFSET: begin
               next_state.rdata[IRQ_WIDTH-1:0] = state.irq_status;
            end
            IRQ_MASK_OFFSET: begin
               next_state.rdata[IRQ_WIDTH-1:0] = state.irq_mask;
            end
            default: begin
               next_state.rdata = '0;
            end
         endcase
      end
   end

   // ===========================================================
   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state                        <= '0;
         state.dir_pend               <= DIR_SEL_RESET;
         state.fwd_dis_pend           <= FWD_DIS_RESET;
         state.rev_dis_pend           <= REV_DIS_RESET;
         state.stop_pend              <= STOP_SEL_RESET;
         state.alloc_fwd_pend         <= ALLOC_FWD_CODE;
         state.alloc_rev_pend         <= ALLOC_REV_CODE;
         state.direction_select       <= DIR_SEL_RESET;
         state.forward_limit_disable  <= FWD_DIS_RESET;
         state.reverse_limit_disable  <= REV_DIS_RESET;
         state.overtravel_stop_select <= STOP_DB_COAST;
         state.limit_enable           <= 1'b1;
         state.motion                 <= MOTION_RUN;
         state.irq_mask               <= IRQ_MASK_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ===========================================================
   // outputs
   always_comb begin
      // forward maps to CCW when select is 0, reverse opposite
      rotate_ccw = (state.motion == MOTION_RUN)
                   && ((forward_ref && !forward_ot && !state.direction_select)
                   || (reverse_ref && !reverse_ot
                       && state.direction_select));
      rotate_cw  = (state.motion == MOTION_RUN)
                   && ((forward_ref && !forward_ot && state.direction_select)
                   || (reverse_ref && !reverse_ot
                       && !state.direction_select));
      dynamic_brake = state.motion == MOTION_DB;
      reverse_brake = state.motion == MOTION_RBRK;
      coasting      = (state.motion == MOTION_FREE)
                      || (state.motion == MOTION_IDLE);
      zero_clamp    = state.motion == MOTION_CLAMP;
   end

   assign clamp_position      = state.clamp_pos;
   assign divided_phase_a_out = state.quad[1];
   assign divided_phase_b_out = state.quad[0];
   assign reg_rdata           = state.rdata;
   assign irq                 = |(state.irq_status & state.irq_mask);

endmodule
`default_nettype wire

//--- overtravel_props.sv
// Purpose: concurrent checks on the overtravel/direction block ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   attached to the block by the bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module overtravel_props (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // limits, references and feedback
   input wire logic        forward_limit_input,
   input wire logic        forward_ref,
   input wire logic        reverse_ref,
   input wire logic        motor_stopped,
   input wire logic        encoder_step,
   input wire logic [31:0] position_in,
   // drive outputs
   input wire logic        rotate_cw,
   input wire logic        rotate_ccw,
   input wire logic        dynamic_brake,
   input wire logic        reverse_brake,
   input wire logic        coasting,
   input wire logic        zero_clamp,
   input wire logic [31:0] clamp_position,
   input wire logic        divided_phase_a_out,
   input wire logic        divided_phase_b_out
);
   logic moving;
   logic fwd_only;
   logic rev_only;

   // =============================================================
   // helpers
   assign moving   = rotate_cw | rotate_ccw;
   assign fwd_only = forward_ref & ~reverse_ref;
   assign rev_only = reverse_ref & ~forward_ref;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // =============================================================
   // assertions
   dir_exclusive_a: assert property (!(rotate_cw && rotate_ccw))
      else $error("both rotation senses driven");
   dir_needs_ref_a: assert property (
      moving |-> forward_ref || reverse_ref)
      else $error("rotation without a reference");
   stop_no_run_a: assert property (
      (dynamic_brake || reverse_brake || zero_clamp) |-> !moving)
      else $error("rotation during stop or clamp");
   rbrk_exit_a: assert property (
      reverse_brake && motor_stopped
      |=> !reverse_brake && (zero_clamp || coasting))
      else $error("reverse brake did not end on standstill");
   dbrk_exit_a: assert property (
      dynamic_brake && motor_stopped |=> coasting && !dynamic_brake)
      else $error("dynamic brake did not end in coasting");
   clamp_latch_a: assert property (
      $rose(zero_clamp) |-> clamp_position == $past(position_in))
      else $error("clamp position not latched at entry");
   clamp_hold_a: assert property (
      zero_clamp ##1 zero_clamp |-> $stable(clamp_position))
      else $error("clamp position moved during clamp");
   quad_fwd_a: assert property (
      encoder_step && fwd_only |=> {divided_phase_a_out, divided_phase_b_out}
      == {$past(divided_phase_b_out), !$past(divided_phase_a_out)})
      else $error("forward step broke B-leads order");
   quad_rev_a: assert property (
      encoder_step && rev_only |=> {divided_phase_a_out, divided_phase_b_out}
      == {!$past(divided_phase_b_out), $past(divided_phase_a_out)})
      else $error("reverse step broke A-leads order");
   sync_delay_a: assert property (
      moving && fwd_only && $fell(forward_limit_input) ##1 fwd_only
      |-> moving)
      else $error("limit acted before two sync stages");

   // main scenarios reached
   cover property (reverse_brake ##1 zero_clamp);
   cover property (dynamic_brake ##1 coasting);
   cover property (encoder_step && rev_only);
endmodule

bind overtravel_direction_logic overtravel_props chk_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .forward_ref(forward_ref),
   .forward_limit_input(forward_limit_input), .reverse_ref(reverse_ref),
   .motor_stopped(motor_stopped), .encoder_step(encoder_step),
   .position_in(position_in), .rotate_cw(rotate_cw), .rotate_ccw(rotate_ccw),
   .dynamic_brake(dynamic_brake), .reverse_brake(reverse_brake),
   .coasting(coasting), .zero_clamp(zero_clamp),
   .clamp_position(clamp_position),
   .divided_phase_a_out(divided_phase_a_out),
   .divided_phase_b_out(divided_phase_b_out));
`default_nettype wire

//--- motor_model.sv
// Purpose: motor shaft seen by the drive: position and standstill
// Assumes: rotate commands move the shaft one count per cycle
// Notes:   standstill reported only after a quiet settle period
`timescale 1ns/100ps
`default_nettype none
module motor_model #(
   parameter int SETTLE_CYCLES = 4
) (
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_b,
   // drive commands
   input  wire logic   rotate_cw,
   input  wire logic   rotate_ccw,
   // mechanical feedback
   output logic        motor_stopped,
   output logic [31:0] position_in
);
   int quiet;

   // shaft position and quiet-cycle count
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         quiet <= 0;
         position_in <= 32'h0000_1000;
      end else if (rotate_cw || rotate_ccw) begin
         quiet <= 0;
         position_in <= rotate_ccw ? position_in + 32'h1 : position_in - 32'h1;
      end else if (quiet < SETTLE_CYCLES) begin
         quiet <= quiet + 1;
      end
   end
   assign motor_stopped = (quiet == SETTLE_CYCLES);
endmodule
`default_nettype wire

//--- overtravel_direction_logic_tb.sv
// Purpose: directed bench for the overtravel/direction block
// Assumes: register port with read data one cycle after the strobe
// Notes:   motor feedback comes from the shaft model
`timescale 1ns/100ps
`default_nettype none
module overtravel_direction_logic_tb;
   import overtravel_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic        forward_limit_input = 1'b1;
   logic        reverse_limit_input = 1'b1;
   logic        forward_ref = 1'b0;
   logic        reverse_ref = 1'b0;
   logic        encoder_step = 1'b0;
   logic [31:0] reg_rdata, position_in, clamp_position;
   logic        irq, motor_stopped, rotate_cw, rotate_ccw, coasting;
   logic        dynamic_brake, reverse_brake, zero_clamp, pha, phb, rev;
   logic [1:0]  sel;
   logic [1:0]  fwd_seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
   logic [1:0]  rev_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
   int          miscompares = 0;
   int          check_count = 0;

   always #12.5 ref_clk = ~ref_clk;

   overtravel_direction_logic dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
      .forward_limit_input(forward_limit_input), .forward_ref(forward_ref),
      .reverse_limit_input(reverse_limit_input), .reverse_ref(reverse_ref),
      .motor_stopped(motor_stopped), .encoder_step(encoder_step),
      .position_in(position_in), .rotate_cw(rotate_cw), .coasting(coasting),
      .rotate_ccw(rotate_ccw), .dynamic_brake(dynamic_brake),
      .reverse_brake(reverse_brake), .zero_clamp(zero_clamp),
      .clamp_position(clamp_position), .divided_phase_a_out(pha),
      .divided_phase_b_out(phb));
   motor_model motor_u (.ref_clk(ref_clk), .rst_b(rst_b),
      .rotate_cw(rotate_cw), .rotate_ccw(rotate_ccw),
      .motor_stopped(motor_stopped), .position_in(position_in));

   // =============================================================
   // compare, bus and stimulus tasks
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      chk_word(reg_rdata & m, exp);
   endtask
   task automatic setup(input logic [31:0] cfg, input logic [31:0] alloc);
      wr(CONFIG_OFFSET, cfg);
      wr(ALLOC_OFFSET, alloc);
      wr(RESTART_OFFSET, 32'h1 << RESTART_BIT);
   endtask
   task automatic drive(input logic f, input logic r, input logic fl,
                        input logic rl);
      @(posedge ref_clk);
      forward_ref <= f;
      reverse_ref <= r;
      forward_limit_input <= fl;
      reverse_limit_input <= rl;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic step(input logic [1:0] exp);
      @(posedge ref_clk);
      encoder_step <= 1'b1;
      @(posedge ref_clk);
      encoder_step <= 1'b0;
      #1;
      chk_word({30'h0, pha, phb}, {30'h0, exp});
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      #200000;
      miscompares++;
      summarize();
   end

   // =============================================================
   // test sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(IRQ_STATUS_OFFSET, 32'h7);
      rd_chk(CONFIG_OFFSET, 32'h1f, 32'h0);
      rd_chk(ALLOC_OFFSET, 32'hff, 32'h21);
      rd_chk(STATUS_OFFSET, 32'h43, 32'h40);
      rd_chk(IRQ_MASK_OFFSET, 32'h7, 32'h0);
      rd_chk(8'h3c, 32'hffff_ffff, 32'h0);
      chk_bit(irq, 1'b0);
      // divided output order in both senses
      drive(1'b1, 1'b0, 1'b1, 1'b1);
      chk_bit(rotate_ccw, 1'b1);
      for (int k = 0; k < 4; k++) step(fwd_seq[k]);
      drive(1'b0, 1'b1, 1'b1, 1'b1);
      for (int k = 0; k < 4; k++) step(rev_seq[k]);
      // rotation sense for both direction settings
      for (int d = 0; d < 2; d++) begin
         setup(32'(d) << DIR_SEL_BIT, 32'h21);
         drive(1'b1, 1'b0, 1'b1, 1'b1);
         chk_bit(rotate_ccw, d == 0);
         chk_bit(rotate_cw, d == 1);
         drive(1'b0, 1'b1, 1'b1, 1'b1);
         chk_bit(rotate_cw, d == 0);
         drive(1'b0, 1'b0, 1'b1, 1'b1);
      end
      // overtravel stop for every method, forward then reverse
      for (int i = 0; i < 8; i++) begin
         sel = i[1:0];
         rev = i[2];
         setup(32'(sel) << STOP_SEL_LSB, 32'h21);
         wr(IRQ_MASK_OFFSET, 32'h7);
         drive(!rev, rev, rev, !rev);
         chk_bit(rotate_cw | rotate_ccw, 1'b0);
         chk_bit(dynamic_brake, sel == 2'd0);
         chk_bit(reverse_brake, sel[1]);
         chk_bit(coasting, sel == 2'd1);
         repeat (6) @(posedge ref_clk);
         #1;
         chk_bit(zero_clamp, sel == 2'd2);
         chk_bit(coasting, sel != 2'd2);
         if (sel == 2'd2) chk_word(clamp_position, position_in);
         rd_chk(STATUS_OFFSET, 32'h3, {30'h0, rev, !rev});
         rd_chk(IRQ_STATUS_OFFSET, 32'h7, {29'h0, 1'b1, rev, !rev});
         chk_bit(irq, 1'b1);
         wr(IRQ_MASK_OFFSET, 32'h0);
         #1;
         chk_bit(irq, 1'b0);
         wr(IRQ_MASK_OFFSET, 32'h7);
         drive(1'b0, 1'b0, 1'b1, 1'b1);
         wr(IRQ_STATUS_OFFSET, 32'h7);
         #1;
         chk_bit(irq, 1'b0);
      end
      // disabled inputs, then unallocated inputs, with both limits open
      for (int j = 0; j < 2; j++) begin
         setup(j ? 32'h0 : 32'h6, j ? 32'h0 : 32'h21);
         drive(1'b1, 1'b0, 1'b0, 1'b0);
         chk_bit(rotate_ccw, 1'b1);
         drive(1'b0, 1'b1, 1'b0, 1'b0);
         chk_bit(rotate_cw, 1'b1);
         rd_chk(STATUS_OFFSET, 32'h43, j ? 32'h0 : 32'h40);
      end
      drive(1'b0, 1'b0, 1'b1, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
